// ===== eria_checker.sv
`timescale 1ns/1ps
module eria_checker (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [4:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Extended port
    input wire logic o_ext_wr,
    input wire logic o_ext_rd,
    input wire logic [15:0] o_ext_addr,
    input wire logic [15:0] i_ext_rdata
);
    logic [1:0] fn_q;
    logic [4:0] dev_q;
    wire ad_wr = i_reg_wr && i_reg_addr == 5'h0E;
    wire dat_wr = ad_wr && dev_q == 5'h1F && fn_q != 2'h0;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fn_q <= 2'h0;
            dev_q <= 5'h00;
        end else if (i_reg_wr && i_reg_addr == 5'h0D) begin
            fn_q <= i_reg_wdata[15:14];
            dev_q <= i_reg_wdata[4:0];
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    read_latency_a: assert property (i_reg_rd && !i_reg_wr |-> ##2 o_reg_rvalid) else $error("late answer");
    stray_answer_a: assert property (o_reg_rvalid |-> $past(i_reg_rd, 2)) else $error("stray answer");
    data_write_a: assert property (dat_wr |=> o_ext_wr) else $error("no ext write");
    foreign_target_a: assert property ((ad_wr || i_reg_rd && i_reg_addr == 5'h0E) && dev_q != 5'h1F
        |=> !o_ext_wr && !o_ext_rd) else $error("foreign target acted");
    addr_fn_silent_a: assert property (ad_wr && fn_q == 2'h0 |=> !o_ext_wr) else $error("ext write on load");
    pointer_step_a: assert property (dat_wr ##1 dat_wr
        |=> o_ext_addr == $past(o_ext_addr) + {15'h0000, fn_q != 2'h1}) else $error("bad step");
    read_data_a: assert property (o_ext_rd |=> o_reg_rvalid && o_reg_rdata == $past(i_ext_rdata))
        else $error("bad read data");
    reserved_zero_a: assert property (o_reg_rvalid && $past(i_reg_addr, 2) == 5'h0D
        |-> o_reg_rdata[13:5] == 9'h000) else $error("reserved bits set");
endmodule
bind eria_top eria_checker i_eria_checker (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_ext_wr(o_ext_wr), .o_ext_rd(o_ext_rd), .o_ext_addr(o_ext_addr),
    .i_ext_rdata(i_ext_rdata));

// ===== eria_ext_model.sv
`timescale 1ns/1ps
module eria_ext_model (
    // Clock
    input wire logic i_ref_clk,
    // Access from the block
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    // Read answer
    output logic [15:0] o_rdata
);
    logic [15:0] mem_q [16];
    logic [15:0] idle_q = 16'h5A5A;
    initial for (int k = 0; k < 16; k++) mem_q[k] = 16'h0000;
    always @(posedge i_ref_clk) begin
        idle_q <= ~idle_q;
        if (i_wr) mem_q[i_addr[3:0]] <= i_wdata;
    end
    // Idle value flips each cycle so a late sample never matches by luck
    assign o_rdata = i_rd ? mem_q[i_addr[3:0]] : idle_q;
endmodule

// ===== eria_pkg.sv
package eria_pkg;

    // Access function held in the control register
    typedef enum logic [1:0] {
        ERIA_FN_ADDR = 2'h0,
        ERIA_FN_DATA = 2'h1,
        ERIA_FN_INC_RW = 2'h2,
        ERIA_FN_INC_WR = 2'h3
    } eria_fn_t;

endpackage

// ===== eria_ptr.sv
`timescale 1ns/1ps
`include "eria_regs.svh"

module eria_ptr (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Update controls
    input wire logic i_load,
    input wire logic [15:0] i_load_val,
    input wire logic i_inc,
    // Pointer value
    output logic [15:0] o_ptr
);

    logic [15:0] ptr_q;
    logic [15:0] ptr_d;

    // Load takes priority; the increment wraps at sixteen bits
    assign ptr_d = i_load ? i_load_val : (i_inc ? 16'(ptr_q + 16'h0001) : ptr_q);

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ptr_q <= `ERIA_RST_PTR;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    assign o_ptr = ptr_q;

endmodule

// ===== eria_regs.svh
`ifndef ERIA_REGS_SVH
`define ERIA_REGS_SVH

// ------------------------------------------------------------
// Management addresses
// ------------------------------------------------------------
`define ERIA_ADDR_CTRL 5'h0D
`define ERIA_ADDR_ADDR_DATA 5'h0E
`define ERIA_DIRECT_TOP 16'h001F

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define ERIA_CTRL_FN_HI 15
`define ERIA_CTRL_FN_LO 14
`define ERIA_CTRL_DEV_HI 4
`define ERIA_CTRL_DEV_LO 0
`define ERIA_DEV_OWN 5'h1F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ERIA_RST_FN 2'h0
`define ERIA_RST_DEV 5'h00
`define ERIA_RST_PTR 16'h0000
`define ERIA_RST_DATA 16'h0000

`endif

// ===== eria_top.sv
`timescale 1ns/1ps
`include "eria_regs.svh"

// Functional notes
// - The control register sits at management address 0x0D and the address/data register at 0x0E, the only way in.
// - Extended registers above 0x1F are reached only through the pointer behind the address/data register.
// - With function code 00 a write to the address/data register loads the pointer with the written value.
// - With function code 01 an address/data access reaches the pointed register and leaves the pointer alone.
// - With function code 10 the pointed register is accessed and the pointer steps after every read and write.
// - With function code 11 the pointer steps after writes only and stays put after reads.
// - A five-bit target field is held and indirect accesses act only when it is all ones, else they are ignored.
// - Control bits 13:5 ignore writes and read as zero.
module eria_top (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Management register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [4:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Extended register port
    output logic o_ext_wr,
    output logic o_ext_rd,
    output logic [15:0] o_ext_addr,
    output logic [15:0] o_ext_wdata,
    input wire logic [15:0] i_ext_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    eria_pkg::eria_fn_t fn_q;
    eria_pkg::eria_fn_t fn_d;
    logic [4:0] dev_q;
    logic [4:0] dev_d;
    logic [15:0] ptr;
    logic ext_wr_q;
    logic ext_rd_q;
    logic [15:0] ext_addr_q;
    logic [15:0] ext_wdata_q;
    logic rd_pend_q;
    logic ext_sel_q;
    logic [15:0] local_q;
    logic [15:0] rdata_q;
    logic rvalid_q;

    // ------------------------------------------------------------
    // Decode nets
    // ------------------------------------------------------------
    logic acc_wr;
    logic acc_rd;
    logic hit_ctrl;
    logic hit_ad;
    logic dev_ok;
    logic fn_addr;
    logic ad_wr;
    logic ad_rd;
    logic ext_wr_go;
    logic ext_rd_go;
    logic ptr_load;
    logic inc_rw;
    logic inc_wo;
    logic ptr_inc;
    logic ctrl_wr;
    logic [15:0] ctrl_rd_val;
    logic [15:0] ad_rd_val;
    logic [15:0] local_d;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // A read and a write in the same cycle: the write wins, the read is dropped
    assign acc_wr = i_reg_wr;
    assign acc_rd = i_reg_rd && !i_reg_wr;
    assign hit_ctrl = (i_reg_addr == `ERIA_ADDR_CTRL);
    assign hit_ad = (i_reg_addr == `ERIA_ADDR_ADDR_DATA);
    assign dev_ok = (dev_q == `ERIA_DEV_OWN);
    assign fn_addr = (fn_q == eria_pkg::ERIA_FN_ADDR);
    assign ad_wr = acc_wr && hit_ad && dev_ok;
    assign ad_rd = acc_rd && hit_ad && dev_ok;
    // Only these two strobes ever reach the extended space
    assign ext_wr_go = ad_wr && !fn_addr;
    assign ext_rd_go = ad_rd && !fn_addr;
    assign ptr_load = ad_wr && fn_addr;
    assign inc_rw = (fn_q == eria_pkg::ERIA_FN_INC_RW);
    assign inc_wo = (fn_q == eria_pkg::ERIA_FN_INC_WR);
    // Code 01 never steps the pointer
    assign ptr_inc = (ext_wr_go && (inc_rw || inc_wo)) || (ext_rd_go && inc_rw);

    // Control write: middle bits are dropped on the floor
    assign ctrl_wr = acc_wr && hit_ctrl;
    assign fn_d = ctrl_wr ? eria_pkg::eria_fn_t'(i_reg_wdata[`ERIA_CTRL_FN_HI:`ERIA_CTRL_FN_LO]) : fn_q;
    assign dev_d = ctrl_wr ? i_reg_wdata[`ERIA_CTRL_DEV_HI:`ERIA_CTRL_DEV_LO] : dev_q;

    // Local read value: middle control bits read back as zero
    assign ctrl_rd_val = {fn_q, 9'h000, dev_q};
    // Under code 00 the address/data register reads back the pointer
    assign ad_rd_val = (dev_ok && fn_addr) ? ptr : 16'h0000;
    // Taken at the request edge, so a control write just after a read cannot leak into its answer
    assign local_d = hit_ctrl ? ctrl_rd_val : (hit_ad ? ad_rd_val : 16'h0000);

    // ------------------------------------------------------------
    // Pointer
    // ------------------------------------------------------------
    // The old pointer is captured for the access in the same edge that steps it,
    // so the increment always lands after the access it belongs to.
    eria_ptr u_ptr (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_load(ptr_load),
        .i_load_val(i_reg_wdata),
        .i_inc(ptr_inc),
        .o_ptr(ptr)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fn_q <= eria_pkg::eria_fn_t'(`ERIA_RST_FN);
        end else begin
            fn_q <= fn_d;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dev_q <= `ERIA_RST_DEV;
        end else begin
            dev_q <= dev_d;
        end
    end

    // ------------------------------------------------------------
    // Extended access strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_wr_q <= 1'b0;
            ext_rd_q <= 1'b0;
        end else begin
            ext_wr_q <= ext_wr_go;
            ext_rd_q <= ext_rd_go;
        end
    end

    // Address and data hold after the strobe, so a slow far side may still use them
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_addr_q <= `ERIA_RST_PTR;
        end else if (ext_wr_go || ext_rd_go) begin
            ext_addr_q <= ptr;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_wdata_q <= `ERIA_RST_DATA;
        end else if (ext_wr_go) begin
            ext_wdata_q <= i_reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read return, two cycles after the request
    // ------------------------------------------------------------
    // The extended side answers combinationally while o_ext_rd is high
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_pend_q <= 1'b0;
            ext_sel_q <= 1'b0;
            rvalid_q <= 1'b0;
        end else begin
            rd_pend_q <= acc_rd;
            ext_sel_q <= ext_rd_go;
            rvalid_q <= rd_pend_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            local_q <= `ERIA_RST_DATA;
        end else begin
            local_q <= local_d;
        end
    end

    // Read data holds between answers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= `ERIA_RST_DATA;
        end else if (rd_pend_q) begin
            rdata_q <= ext_sel_q ? i_ext_rdata : local_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs, register port
    // ------------------------------------------------------------
    assign o_reg_rdata = rdata_q;
    assign o_reg_rvalid = rvalid_q;

    // ------------------------------------------------------------
    // Outputs, extended port
    // ------------------------------------------------------------
    assign o_ext_wr = ext_wr_q;
    assign o_ext_rd = ext_rd_q;
    assign o_ext_addr = ext_addr_q;
    assign o_ext_wdata = ext_wdata_q;

endmodule

// ===== extended_register_indirect_access_bench.sv
`timescale 1ns/1ps
module extended_register_indirect_access_bench;
    logic clk = 0, arst_n = 0, wr = 0, rd = 0, ewr, erd;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000, rdata, eaddr, ewdata, erdata, p, d;
    logic rvalid;
    int mismatches = 0, num_checks = 0, cyc = 0, ext_cnt = 0, n;
    eria_top i_eria_top (.i_ref_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_ext_wr(ewr), .o_ext_rd(erd),
        .o_ext_addr(eaddr), .o_ext_wdata(ewdata), .i_ext_rdata(erdata));
    eria_ext_model i_eria_ext_model (.i_ref_clk(clk), .i_wr(ewr), .i_rd(erd), .i_addr(eaddr),
        .i_wdata(ewdata), .o_rdata(erdata));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (ewr || erd) ext_cnt++;
        if (cyc == 3000) begin
            mismatches++;
            conclude;
        end
    end
    task check(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task reg_wr(input logic [4:0] a, input logic [15:0] v);
        addr = a;
        wdata = v;
        wr = 1;
        @(negedge clk) wr = 0;
        @(negedge clk);
    endtask
    task reg_wr2(input logic [15:0] v0, input logic [15:0] v1);
        addr = 5'h0E;
        wdata = v0;
        wr = 1;
        @(negedge clk) wdata = v1;
        @(negedge clk) wr = 0;
        @(negedge clk);
    endtask
    task reg_rd(input logic [4:0] a, input logic [15:0] e, input bit c);
        addr = a;
        rd = 1;
        @(negedge clk) rd = 0;
        @(negedge clk);
        check("answer", 16'h0001, {15'h0000, rvalid});
        if (c) check("rdata", e, rdata);
    endtask
    // Two writes plus one read per burst; only some codes step on each
    function logic [15:0] steps(input logic [1:0] f);
        return f == 2'h2 ? 16'h0003 : f == 2'h3 ? 16'h0002 : 16'h0000;
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hAD10));
        repeat (6) @(negedge clk);
        arst_n = 1;
        @(negedge clk);
        reg_rd(5'h0D, 16'h0000, 1);
        reg_rd(5'h03, 16'h0000, 1);
        $display("test reset done");
        reg_wr(5'h0D, 16'hFFE0);
        reg_rd(5'h0D, 16'hC000, 1);
        n = ext_cnt;
        reg_wr(5'h0E, 16'($urandom));
        reg_rd(5'h0E, 16'h0000, 1);
        check("strobes", 16'(n), 16'(ext_cnt));
        $display("test target done");
        for (int i = 1; i < 4; i++) begin
            p = i == 2 ? 16'hFFFF : 16'($urandom);
            d = 16'($urandom);
            reg_wr(5'h0D, 16'h001F);
            reg_wr(5'h0E, p);
            reg_rd(5'h0E, p, 1);
            reg_wr(5'h0D, {2'(i), 14'h001F});
            reg_wr2(d, ~d);
            reg_rd(5'h0E, 16'h0000, 0);
            reg_wr(5'h0D, 16'h001F);
            reg_rd(5'h0E, p + steps(2'(i)), 1);
            reg_wr(5'h0E, p);
            reg_wr(5'h0D, 16'h401F);
            reg_rd(5'h0E, i == 1 ? ~d : d, 1);
            $display("test function %0d done", i);
        end
        conclude;
    end
endmodule
